// *** modem_line_control.sv ***
// Modem line control for one serial channel: control register, prescale,
// infrared path select, loopback and interrupt output gating.
// Assumes a single AHB-Lite master and one clock; pins are synchronous.

`timescale 1ns/1ps
`default_nettype none

module modem_line_control
    import modem_line_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,

    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,

    // Serial streams to and from the channel
    input wire logic tx_serial,
    output logic rx_serial,
    output logic baud_tick,

    // Serial pins
    output logic tx_pin,
    input wire logic rx_pin,
    output logic ir_tx_pin,
    input wire logic ir_rx_pin,

    // Modem pins
    input wire modem_pins_s modem_pins,
    output logic rts_n,
    output logic dtr_n,
    output logic aux_output_two,

    // Interrupt requests and output
    input wire chan_req_s chan_req,
    output logic irq_out,
    output logic irq_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    ctl_state_s s;
    ctl_state_s next_s;

    logic addr_ok;
    logic [3:0] src_lvl;
    logic [3:0] edge_set;
    logic [3:0] clr_mask;
    logic loop_on;
    logic any_irq;

    // Address phase accepted
    assign addr_ok = hsel && htrans[1] && hready;

    // Loopback flag from the register
    assign loop_on = s.mlc[MLC_LOOP];

    // ------------------------------------------------------------
    // Modem status sources
    // ------------------------------------------------------------

    // Order is {cd, ri, dsr, cts}
    always_comb begin
        if (loop_on) begin
            src_lvl = {s.mlc[MLC_AUX2], s.mlc[MLC_AUX1],  // see RL8, see RL12
                       s.mlc[MLC_DTR], s.mlc[MLC_RTS]};   // see RL16, see RL6
        end else begin
            src_lvl = ~{modem_pins.cd_n, modem_pins.ri_n,  // see RL5
                        modem_pins.dsr_n, modem_pins.cts_n};
        end
    end

    // Change detect; ring indicator reports its trailing edge
    always_comb begin
        edge_set[0] = s.lvl[0] ^ src_lvl[0];
        edge_set[1] = s.lvl[1] ^ src_lvl[1];
        edge_set[2] = s.lvl[2] & ~src_lvl[2];
        edge_set[3] = s.lvl[3] ^ src_lvl[3];
    end

    // Gated interrupt sources
    always_comb begin
        any_irq = (chan_req.rx && s.ien[IEN_RX])         // see RL7, see RL9
               || (chan_req.tx && s.ien[IEN_TX])
               || (chan_req.line && s.ien[IEN_LINE])
               || ((|s.delta) && s.ien[IEN_MODEM]);     // see RL8
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        next_s = s;
        clr_mask = 4'h0;

        // Data phase write
        if (s.dph_wr) begin
            if (s.dph_addr == ADDR_MLC) begin
                next_s.mlc = hwdata[7:0] & MLC_WMASK;  // see RL4
            end else if (s.dph_addr == ADDR_IEN) begin
                next_s.ien = hwdata[3:0];
            end else if (s.dph_addr == ADDR_MSV) begin
                clr_mask = hwdata[3:0];
            end
        end

        // Sticky deltas; a new change wins over the clear
        next_s.lvl = src_lvl;
        next_s.delta = (s.delta & ~clr_mask) | edge_set;

        // Address phase capture and read data
        next_s.dph_wr = addr_ok && hwrite;
        next_s.dph_addr = haddr[7:0];
        next_s.hrdata = 32'h0;
        if (addr_ok && !hwrite) begin
            if (haddr[7:0] == ADDR_MLC) begin
                next_s.hrdata = {24'h0, s.mlc};
            end else if (haddr[7:0] == ADDR_IEN) begin
                next_s.hrdata = {28'h0, s.ien};
            end else if (haddr[7:0] == ADDR_MSV) begin
                next_s.hrdata = {24'h0, s.lvl, s.delta};
            end else begin
                next_s.hrdata = 32'h0;
            end
        end

        // Baud prescale enable
        next_s.pre = s.pre + 2'h1;
        if (s.mlc[MLC_CLKDIV]) begin
            next_s.baud_tick = (s.pre == PRESCALE_LAST);  // see RL1
        end else begin
            next_s.baud_tick = 1'b1;                      // see RL1
        end

        // Serial path select
        if (loop_on) begin
            next_s.rx_serial = tx_serial;   // see RL15, see RL6
            next_s.tx_pin = 1'b1;           // see RL15, see RL5
            next_s.ir_tx_pin = 1'b0;        // see RL3
        end else if (s.mlc[MLC_IR]) begin
            next_s.rx_serial = ~ir_rx_pin;  // see RL2
            next_s.tx_pin = 1'b1;
            next_s.ir_tx_pin = ~tx_serial;  // see RL2, see RL3
        end else begin
            next_s.rx_serial = rx_pin;
            next_s.tx_pin = tx_serial;
            next_s.ir_tx_pin = 1'b0;        // see RL3
        end

        // Modem outputs, inverted
        next_s.rts_n = ~s.mlc[MLC_RTS];  // see RL13
        next_s.dtr_n = ~s.mlc[MLC_DTR];  // see RL14

        // Interrupt output and auxiliary two
        next_s.aux_output_two = ~s.mlc[MLC_AUX2];  // see RL10, see RL11
        next_s.irq_oe = s.mlc[MLC_AUX2];           // see RL10, see RL11
        next_s.irq_out = any_irq && s.mlc[MLC_AUX2];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Reset to normal modem mode, no loopback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.mlc <= MLC_RESET;
            s.ien <= IEN_RESET;
            s.tx_pin <= 1'b1;
            s.rx_serial <= 1'b1;
            s.rts_n <= 1'b1;
            s.dtr_n <= 1'b1;
            s.aux_output_two <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Zero wait state, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;

    // Pins straight from the state
    assign baud_tick = s.baud_tick;
    assign tx_pin = s.tx_pin;
    assign ir_tx_pin = s.ir_tx_pin;
    assign rx_serial = s.rx_serial;
    assign rts_n = s.rts_n;
    assign dtr_n = s.dtr_n;
    assign aux_output_two = s.aux_output_two;
    assign irq_out = s.irq_out;
    assign irq_oe = s.irq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // Divide by one gives a tick every cycle
    a_prescale_div1: assert property (  // see RL1
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && !s.mlc[MLC_CLKDIV]) |=> baud_tick
    ) else $error("prescale by one missed a tick");

    // Divide by four never ticks twice in a row
    a_prescale_div4: assert property (  // see RL1
        @(posedge hclk) disable iff (!hresetn)
        (baud_tick && $past(s.mlc[MLC_CLKDIV])
         && $past(s.mlc[MLC_CLKDIV], 2)) |-> !$past(baud_tick)
    ) else $error("prescale by four ticked back to back");

    // Infrared transmit idles low
    a_ir_idle_low: assert property (  // see RL3
        @(posedge hclk) disable iff (!hresetn)
        tx_serial |=> !ir_tx_pin
    ) else $error("infrared output high while idle");

    // Loopback serial path
    a_loop_serial: assert property (  // see RL15
        @(posedge hclk) disable iff (!hresetn)
        loop_on |=> (rx_serial == $past(tx_serial)) && tx_pin
    ) else $error("loopback serial path wrong");

    // Loopback modem sources
    a_loop_modem_src: assert property (  // see RL16
        @(posedge hclk) disable iff (!hresetn)
        loop_on |=> s.lvl == {$past(s.mlc[MLC_AUX2]),
            $past(s.mlc[MLC_AUX1]), $past(s.mlc[MLC_DTR]),
            $past(s.mlc[MLC_RTS])}
    ) else $error("loopback modem source wrong");

    // Inverted RTS and DTR
    a_rts_dtr_drive: assert property (  // see RL13
        @(posedge hclk) disable iff (!hresetn)
        ##1 (rts_n != $past(s.mlc[MLC_RTS]))
            && (dtr_n != $past(s.mlc[MLC_DTR]))
    ) else $error("RTS or DTR not inverted from control");

    // Interrupt output enable and auxiliary two are opposite
    a_irq_enable_aux: assert property (  // see RL10
        @(posedge hclk) disable iff (!hresetn)
        ##1 (irq_oe == $past(s.mlc[MLC_AUX2]))
            && (aux_output_two == !irq_oe)
    ) else $error("interrupt enable or auxiliary two wrong");

    // Masked sources never raise the interrupt
    a_irq_masked: assert property (  // see RL9
        @(posedge hclk) disable iff (!hresetn)
        (s.ien == 4'h0) |=> !irq_out
    ) else $error("interrupt raised with all enables clear");

    // Receive request passes while loopback is on
    a_loop_rx_irq: assert property (  // see RL7
        @(posedge hclk) disable iff (!hresetn)
        (loop_on && s.mlc[MLC_AUX2] && s.ien[IEN_RX] && chan_req.rx)
            |=> irq_out
    ) else $error("receive interrupt lost in loopback");

    // Infrared transmit follows the inverted stream; standard pin marks
    a_ir_tx_path: assert property (  // see RL2
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && s.mlc[MLC_IR] && !loop_on)
            |=> (ir_tx_pin == !$past(tx_serial)) && tx_pin
    ) else $error("infrared transmit path wrong");

    // Infrared receive pulse decodes to a space
    a_ir_rx_path: assert property (  // see RL2
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && s.mlc[MLC_IR] && !loop_on)
            |=> rx_serial == !$past(ir_rx_pin)
    ) else $error("infrared receive path wrong");

    // Standard path passes both streams and keeps infrared quiet
    a_std_path: assert property (  // see RL2
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && !s.mlc[MLC_IR] && !loop_on)
            |=> (tx_pin == $past(tx_serial)) && (rx_serial == $past(rx_pin))
                && !ir_tx_pin
    ) else $error("standard serial path wrong");

    // Loopback keeps both transmit pins idle
    a_loop_isolate: assert property (  // see RL5
        @(posedge hclk) disable iff (!hresetn)
        loop_on |=> tx_pin && !ir_tx_pin
    ) else $error("transmit pin active in loopback");

    // Outside loopback the levels follow the modem pins
    a_pin_modem_src: assert property (  // see RL5
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && !loop_on) |=> s.lvl == ~$past({modem_pins.cd_n,
            modem_pins.ri_n, modem_pins.dsr_n, modem_pins.cts_n})
    ) else $error("modem levels do not follow pins");

    // A detected change always lands in the sticky deltas
    a_delta_set: assert property (  // see RL8
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && (edge_set != 4'h0))
            |=> (s.delta & $past(edge_set)) == $past(edge_set)
    ) else $error("modem change not recorded");

    // Pending delta with its enable raises the interrupt
    a_modem_irq: assert property (  // see RL8
        @(posedge hclk) disable iff (!hresetn)
        (s.mlc[MLC_AUX2] && s.ien[IEN_MODEM] && (s.delta != 4'h0)) |=> irq_out
    ) else $error("modem interrupt lost");

    // Bit 3 clear floats the interrupt and raises auxiliary two
    a_irq_gate_off: assert property (  // see RL10
        @(posedge hclk) disable iff (!hresetn)
        !s.mlc[MLC_AUX2] |=> !irq_out && !irq_oe && aux_output_two
    ) else $error("interrupt not floated with bit 3 clear");

    // Bit 3 set drives the interrupt and lowers auxiliary two
    a_irq_drive_on: assert property (  // see RL11
        @(posedge hclk) disable iff (!hresetn)
        s.mlc[MLC_AUX2] |=> irq_oe && !aux_output_two
    ) else $error("interrupt not driven with bit 3 set");

    // Enabled line status request reaches the output
    a_line_irq: assert property (  // see RL7
        @(posedge hclk) disable iff (!hresetn)
        (s.mlc[MLC_AUX2] && s.ien[IEN_LINE] && chan_req.line) |=> irq_out
    ) else $error("line status interrupt lost");

    // Enabled transmit request reaches the output
    a_tx_irq: assert property (  // see RL7
        @(posedge hclk) disable iff (!hresetn)
        (s.mlc[MLC_AUX2] && s.ien[IEN_TX] && chan_req.tx) |=> irq_out
    ) else $error("transmit interrupt lost");

    // Divide by four ticks once the counter wraps
    a_div4_tick: assert property (  // see RL1
        @(posedge hclk) disable iff (!hresetn)
        (s.mlc[MLC_CLKDIV] && (s.pre == PRESCALE_LAST)) |=> baud_tick
    ) else $error("prescale by four missed its tick");

    // Divide by four stays quiet between wraps
    a_div4_gap: assert property (  // see RL1
        @(posedge hclk) disable iff (!hresetn)
        (s.mlc[MLC_CLKDIV] && (s.pre != PRESCALE_LAST)) |=> !baud_tick
    ) else $error("prescale by four ticked early");

endmodule : modem_line_control

`default_nettype wire

// *** modem_line_pkg.sv ***
// Constants, carrier structs and state struct for the modem line control block.
// Assumes one 100 MHz clock and an AHB-Lite register bus with word transfers.
//
// Summary of operation
// RL1: Bit 7 set divides the baud clock by four, clear passes every cycle.
// RL2: Bit 6 set routes transmit and receive through the infrared coder.
// RL3: In infrared mode the infrared transmit output idles low.
// RL4: Software writes zero to reserved bit 5.
// RL5: Bit 4 enables loopback, isolating transmit, receive and modem input pins.
// RL6: Loopback ties modem data and control signals together internally.
// RL7: Receive and transmit interrupts keep working in loopback.
// RL8: Loopback modem status sources come from the low four control bits.
// RL9: Each interrupt stays gated by its enable bit in loopback too.
// RL10: Bit 3 clear floats the interrupt output and sets auxiliary output two high.
// RL11: Bit 3 set drives the interrupt output and sets auxiliary output two low.
// RL12: Bit 2 supplies the ring indicator state in loopback only.
// RL13: Bit 1 drives the RTS pin inverted.
// RL14: Bit 0 drives the DTR pin inverted.
// RL15: Loopback feeds transmit stream to receiver; transmit pin stays marking.
// RL16: Loopback maps DTR to DSR, RTS to CTS, auxiliary two to CD.

package modem_line_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MLC = 8'h00;
    localparam logic [7:0] ADDR_IEN = 8'h04;
    localparam logic [7:0] ADDR_MSV = 8'h08;
    localparam logic [7:0] MLC_RESET = 8'h00;
    localparam logic [3:0] IEN_RESET = 4'h0;
    localparam logic [7:0] MLC_WMASK = 8'hdf;
    localparam int MLC_DTR = 0;
    localparam int MLC_RTS = 1;
    localparam int MLC_AUX1 = 2;
    localparam int MLC_AUX2 = 3;
    localparam int MLC_LOOP = 4;
    localparam int MLC_IR = 6;
    localparam int MLC_CLKDIV = 7;
    localparam int IEN_RX = 0;
    localparam int IEN_TX = 1;
    localparam int IEN_LINE = 2;
    localparam int IEN_MODEM = 3;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Modem status pins, active low
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } modem_pins_s;

    // Interrupt requests from the rest of the channel
    typedef struct packed {
        logic line;
        logic tx;
        logic rx;
    } chan_req_s;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] mlc;
        logic [3:0] ien;
        logic [3:0] lvl;
        logic [3:0] delta;
        logic [1:0] pre;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] hrdata;
        logic baud_tick;
        logic tx_pin;
        logic ir_tx_pin;
        logic rx_serial;
        logic rts_n;
        logic dtr_n;
        logic aux_output_two;
        logic irq_out;
        logic irq_oe;
    } ctl_state_s;

endpackage : modem_line_pkg

// *** modem_peer.sv ***
// Far-end modem model: a loop plug on the serial lines, status set by the bench.
// Assumes the bench picks the active-low status levels to present.
`timescale 1ns/1ps
`default_nettype none
module modem_peer
    import modem_line_pkg::*;
(
    // Lines from the device
    input wire logic tx_pin,
    input wire logic ir_tx_pin,
    // Status chosen by the bench, active low
    input wire logic [3:0] status_n,
    // Lines to the device
    output logic rx_pin,
    output logic ir_rx_pin,
    output var modem_pins_s modem_pins
);
    // Loop plug returns both transmit lines
    assign rx_pin = tx_pin;
    assign ir_rx_pin = ir_tx_pin;
    // Status lines as the far end presents them
    assign modem_pins = status_n;
endmodule : modem_peer
`default_nettype wire

// *** uart_modem_line_control_tb_top.sv ***
// Bench for the modem line control block: random and corner register traffic.
// Assumes outputs registered one cycle behind their inputs and an OKAY-only slave.
`timescale 1ns/1ps
`default_nettype none
module uart_modem_line_control_tb_top
    import modem_line_pkg::*;
();
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_serial = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, c;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] pins_n = 4'hf;
    logic [7:0] v;
    logic r;
    chan_req_s chan_req = 3'h0;
    logic hready, hresp, rx_serial, baud_tick, tx_pin, rx_pin, ir_tx_pin, ir_rx_pin;
    logic rts_n, dtr_n, aux2, irq_out, irq_oe;
    logic [31:0] hrdata;
    modem_pins_s modem_pins;
    int fail_count = 0, check_count = 0;

    // Clock at 100 MHz
    always #5 hclk = ~hclk;

    modem_line_control modem_line_control_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .tx_serial(tx_serial), .rx_serial(rx_serial),
        .baud_tick(baud_tick), .tx_pin(tx_pin), .rx_pin(rx_pin), .ir_tx_pin(ir_tx_pin),
        .ir_rx_pin(ir_rx_pin), .modem_pins(modem_pins), .rts_n(rts_n), .dtr_n(dtr_n),
        .aux_output_two(aux2), .chan_req(chan_req), .irq_out(irq_out), .irq_oe(irq_oe));

    modem_peer modem_peer_i (.tx_pin(tx_pin), .ir_tx_pin(ir_tx_pin), .status_n(pins_n),
        .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin), .modem_pins(modem_pins));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One single transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (hready !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask : tick

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h3483077e));
        repeat (2) @(posedge hclk);
        chk({tx_pin, ir_tx_pin, rts_n, dtr_n, aux2, irq_out, irq_oe}, 7'h5c);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 8'h00, q);
        chk(q, 32'h0);
        chk(hresp, 32'h0);
        wr(8'h40, 8'hff);
        bus(1'b0, 8'h40, 8'h00, q);
        chk(q, 32'h0);
        // Random modes without loopback
        repeat (12) begin
            v = 8'($urandom()) & 8'hcf;
            r = 1'($urandom());
            wr(8'h00, v);
            tx_serial <= r;
            pins_n <= 4'($urandom());
            tick(2);
            chk({rts_n, dtr_n, aux2, irq_oe}, {~v[1], ~v[0], ~v[3], v[3]});
            chk({tx_pin, ir_tx_pin}, {v[6] | r, v[6] & ~r});
            tick(1);
            chk(rx_serial, r);
            c = 32'h0;
            repeat (8) begin
                @(posedge hclk);
                c += baud_tick;
            end
            chk(c, v[7] ? 32'h2 : 32'h8);
            bus(1'b0, 8'h00, 8'h00, q);
            chk(q, {24'h0, v});
            bus(1'b0, 8'h08, 8'h00, q);
            chk(q[7:4], {~pins_n});
        end
        // Every loopback control pattern
        for (int k = 0; k < 16; k++) begin
            r = 1'($urandom());
            v = 8'h10 | 8'(k) | (8'($urandom()) & 8'hc0);
            wr(8'h00, v);
            tx_serial <= r;
            pins_n <= 4'($urandom());
            tick(2);
            chk({tx_pin, ir_tx_pin, rx_serial, rts_n, dtr_n},
                {1'b1, 1'b0, r, ~k[1], ~k[0]});
            bus(1'b0, 8'h08, 8'h00, q);
            chk(q[7:4], {k[3], k[2], k[0], k[1]});
        end
        // Interrupts in loopback
        wr(8'h04, 8'h08);
        wr(8'h08, 8'h0f);
        tick(2);
        chk(irq_out, 1'b0);
        wr(8'h00, 8'h1e);
        for (int n = 0; n < 8 && irq_out !== 1'b1; n++) begin
            @(posedge hclk);
        end
        if (irq_out !== 1'b1) begin
            fail_count++;
            complete_run();
        end
        bus(1'b0, 8'h08, 8'h00, q);
        chk(q, 32'hd2);
        wr(8'h04, 8'h00);
        tick(2);
        chk(irq_out, 1'b0);
        for (int i = 0; i < 3; i++) begin
            chan_req <= 3'(1 << i);
            wr(8'h04, 8'(1 << i));
            tick(2);
            chk(irq_out, 1'b1);
            wr(8'h04, 8'h07 ^ 8'(1 << i));
            tick(2);
            chk(irq_out, 1'b0);
        end
        wr(8'h04, 8'h0f);
        wr(8'h00, 8'h10);
        tick(2);
        chk({irq_out, irq_oe, aux2}, 3'h1);
        complete_run();
    end
endmodule : uart_modem_line_control_tb_top
`default_nettype wire
